// ### hdl/adcdc_device.sv
// One converter of the daisy chain: mode capture, conversion, shifting
// ****************************************************************
// Functional notes
// - Serial input low at start: daisy-chain
// - Start rise with serial input low samples input, begins conversion
// - No busy: output low while converting
// - Clock low at start: no busy bit
// - Clock high at start: busy bit
// - Host holds start high through readout
// - Conversion ignores serial clock activity
// - No busy: MSB at end, shift falling
// - Capture serial input each falling edge except the one ending the busy bit
// - First device low after sixteenth fall
// - Forward upstream data after own word
// - Host gives sixteen clocks per device
// - Simultaneous input rise still selects chain
// - Busy: MSB on first fall after busy
// - First device high after seventeenth fall
// - Host gives sixteen per device plus one
// - Busy bit sits just ahead of result
// - Busy bit is driven low
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module adcdc_device #(
    parameter int unsigned CONV_CYCLES = adcdc_pkg::CONV_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    adcdc_if.device link,
    input wire logic [15:0] sample,
    output logic chain_mode,
    output logic busy_mode,
    output logic converting
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535)
    begin
        $error("CONV_CYCLES out of range");
    end
    if (adcdc_pkg::WORD_BITS != 16)
    begin
        $error("Shift register holds sixteen bits");
    end

    logic [1:0] cs_sync_q, ck_sync_q, si_sync_q;
    logic [1:0] cs_sync_d, ck_sync_d, si_sync_d;
    logic cs_prev_q, ck_prev_q, si_prev_q;
    logic cs_prev_d, ck_prev_d, si_prev_d;
    adcdc_pkg::adcdc_dev_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d, sr_q, sr_d;
    logic out_q, out_d, chain_q, chain_d, busy_q, busy_d, conv_q, conv_d;
    logic lead_q, lead_d;
    logic cs_rise, ck_fall, si_at_rise;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always_comb
    begin
        // Two stages before any logic reads a pin
        cs_sync_d = {cs_sync_q[0], link.convert_start};
        ck_sync_d = {ck_sync_q[0], link.sclk};
        si_sync_d = {si_sync_q[0], link.serial_in};
        cs_prev_d = cs_sync_q[1];
        ck_prev_d = ck_sync_q[1];
        si_prev_d = si_sync_q[1];
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_sync_q <= '0;
            ck_sync_q <= '0;
            si_sync_q <= '0;
            cs_prev_q <= 1'b0;
            ck_prev_q <= 1'b0;
            si_prev_q <= 1'b0;
        end
        else
        begin
            cs_sync_q <= cs_sync_d;
            ck_sync_q <= ck_sync_d;
            si_sync_q <= si_sync_d;
            cs_prev_q <= cs_prev_d;
            ck_prev_q <= ck_prev_d;
            si_prev_q <= si_prev_d;
        end
    end

    // ****************************************************************
    // Edge detection and next state
    // ****************************************************************
    always_comb
    begin
        cs_rise = cs_sync_q[1] && !cs_prev_q;
        ck_fall = ck_prev_q && !ck_sync_q[1];
        // Level seen just before the edge, so a shared rise reads low
        si_at_rise = si_prev_q;
        st_d = st_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        out_d = out_q;
        chain_d = chain_q;
        busy_d = busy_q;
        conv_d = conv_q;
        lead_d = lead_q;
        case (st_q)
            adcdc_pkg::ADCDC_IDLE:
            begin
                if (cs_rise && !si_at_rise)
                begin
                    chain_d = 1'b1;
                    busy_d = ck_prev_q;
                    lead_d = ck_prev_q;
                    sr_d = sample;
                    cnt_d = '0;
                    conv_d = 1'b1;
                    out_d = 1'b0;
                    st_d = adcdc_pkg::ADCDC_CONV;
                end
            end
            adcdc_pkg::ADCDC_CONV:
            begin
                // Serial clock edges are not looked at here
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(CONV_CYCLES - 1))
                begin
                    conv_d = 1'b0;
                    st_d = adcdc_pkg::ADCDC_SHIFT;
                    // Word stays whole; its MSB stands or a busy bit leads
                    if (busy_q)
                        out_d = 1'b0;
                    else
                        out_d = sr_q[15];
                end
            end
            adcdc_pkg::ADCDC_SHIFT:
            begin
                if (!cs_sync_q[1])
                begin
                    out_d = 1'b0;
                    chain_d = 1'b0;
                    busy_d = 1'b0;
                    lead_d = 1'b0;
                    st_d = adcdc_pkg::ADCDC_IDLE;
                end
                else if (ck_fall)
                begin
                    if (lead_q)
                    begin
                        // Busy bit ends; the upstream busy bit is not kept
                        out_d = sr_q[15];
                        lead_d = 1'b0;
                    end
                    else
                    begin
                        // Next bit down leaves as the upstream bit enters
                        out_d = sr_q[14];
                        sr_d = {sr_q[14:0], si_sync_q[1]};
                    end
                end
            end
            default:
                st_d = adcdc_pkg::ADCDC_IDLE;
        endcase
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= adcdc_pkg::ADCDC_IDLE;
            cnt_q <= '0;
            sr_q <= adcdc_pkg::SAMPLE_RESET;
            out_q <= 1'b0;
            chain_q <= 1'b0;
            busy_q <= 1'b0;
            conv_q <= 1'b0;
            lead_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            out_q <= out_d;
            chain_q <= chain_d;
            busy_q <= busy_d;
            conv_q <= conv_d;
            lead_q <= lead_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.serial_out = out_q;
    assign chain_mode = chain_q;
    assign busy_mode = busy_q;
    assign converting = conv_q;
endmodule
`default_nettype wire

// ### hdl/adcdc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adcdc_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("FIFO depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;
    always_comb
    begin
        in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
        out_valid = wr_q != rd_q;
        out_data = mem_q[rd_q[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q + (AW+1)'(push);
        rd_d = rd_q + (AW+1)'(pop);
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// ### hdl/adcdc_host.sv
// Host end: starts conversions, clocks the chain, queues result words
`timescale 1ns/1ps
`default_nettype none
module adcdc_host #(
    parameter int unsigned N_DEV = 2,
    parameter int unsigned WAIT_CYCLES = 60,
    parameter int unsigned SCLK_HALF = adcdc_pkg::SCLK_HALF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    adcdc_if.host link,
    input wire logic start,
    input wire logic use_busy,
    output logic running,
    output logic word_valid,
    input wire logic word_ready,
    output logic [15:0] word_data
);
    if (N_DEV < 1 || N_DEV > 64 || SCLK_HALF < 3 || WAIT_CYCLES < 1)
    begin
        $error("Host parameters out of range");
    end
    adcdc_pkg::adcdc_host_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d, bits_q, bits_d, sh_q, sh_d;
    logic [4:0] nb_q, nb_d;
    logic [1:0] so_sync_q;
    logic cs_q, cs_d, ck_q, ck_d, run_q, run_d, push_d, busy_q, busy_d;
    logic f_ready, f_valid;
    logic [15:0] f_data;
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        bits_d = bits_q;
        sh_d = sh_q;
        nb_d = nb_q;
        cs_d = cs_q;
        ck_d = ck_q;
        run_d = run_q;
        push_d = 1'b0;
        busy_d = busy_q;
        case (st_q)
            adcdc_pkg::ADCDC_H_IDLE:
            begin
                if (start)
                begin
                    busy_d = use_busy;
                    ck_d = use_busy;
                    run_d = 1'b1;
                    cnt_d = '0;
                    st_d = adcdc_pkg::ADCDC_H_START;
                end
            end
            adcdc_pkg::ADCDC_H_START:
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(SCLK_HALF))
                begin
                    cs_d = 1'b1;
                    cnt_d = '0;
                    st_d = adcdc_pkg::ADCDC_H_WAIT;
                end
            end
            adcdc_pkg::ADCDC_H_WAIT:
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(SCLK_HALF))
                    ck_d = 1'b0;
                if (cnt_q == 16'(WAIT_CYCLES - 1))
                begin
                    cnt_d = '0;
                    nb_d = '0;
                    // Extra leading clock drops the busy bit
                    bits_d = 16'(N_DEV * adcdc_pkg::WORD_BITS)
                        + 16'(busy_q);
                    ck_d = 1'b1;
                    st_d = adcdc_pkg::ADCDC_H_HIGH;
                end
            end
            adcdc_pkg::ADCDC_H_HIGH:
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(SCLK_HALF - 1))
                begin
                    cnt_d = '0;
                    ck_d = 1'b0;
                    st_d = adcdc_pkg::ADCDC_H_LOW;
                end
            end
            adcdc_pkg::ADCDC_H_LOW:
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(SCLK_HALF - 1))
                begin
                    cnt_d = '0;
                    bits_d = bits_q - 16'h0001;
                    if (busy_q)
                        busy_d = 1'b0;
                    else
                    begin
                        sh_d = {sh_q[14:0], so_sync_q[1]};
                        nb_d = nb_q + 5'd1;
                    end
                    st_d = adcdc_pkg::ADCDC_H_PUSH;
                end
            end
            adcdc_pkg::ADCDC_H_PUSH:
            begin
                if (nb_q == 5'(adcdc_pkg::WORD_BITS))
                begin
                    if (f_ready)
                    begin
                        push_d = 1'b1;
                        nb_d = '0;
                    end
                end
                else if (bits_q == 16'h0000)
                    st_d = adcdc_pkg::ADCDC_H_END;
                else
                begin
                    ck_d = 1'b1;
                    st_d = adcdc_pkg::ADCDC_H_HIGH;
                end
            end
            adcdc_pkg::ADCDC_H_END:
            begin
                cs_d = 1'b0;
                run_d = 1'b0;
                st_d = adcdc_pkg::ADCDC_H_IDLE;
            end
            default:
                st_d = adcdc_pkg::ADCDC_H_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= adcdc_pkg::ADCDC_H_IDLE;
            cnt_q <= '0;
            bits_q <= '0;
            sh_q <= '0;
            nb_q <= '0;
            so_sync_q <= '0;
            cs_q <= 1'b0;
            ck_q <= 1'b0;
            run_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bits_q <= bits_d;
            sh_q <= sh_d;
            nb_q <= nb_d;
            so_sync_q <= {so_sync_q[0], link.serial_out};
            cs_q <= cs_d;
            ck_q <= ck_d;
            run_q <= run_d;
            busy_q <= busy_d;
        end
    end
    adcdc_fifo #(
        .WIDTH(16),
        .DEPTH(adcdc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(push_d),
        .in_ready(f_ready),
        .in_data(sh_q),
        .out_valid(f_valid),
        .out_ready(!word_valid || word_ready),
        .out_data(f_data)
    );
    logic wv_q;
    logic [15:0] wd_q;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wv_q <= 1'b0;
            wd_q <= '0;
        end
        else if (!wv_q || word_ready)
        begin
            wv_q <= f_valid;
            wd_q <= f_data;
        end
    end
    assign link.convert_start = cs_q;
    assign link.sclk = ck_q;
    assign running = run_q;
    assign word_valid = wv_q;
    assign word_data = wd_q;
endmodule
`default_nettype wire

// ### hdl/adcdc_if.sv
// Link between the chain of converters and the host
`timescale 1ns/1ps
`default_nettype none
interface adcdc_if;
    logic convert_start;
    logic sclk;
    logic serial_in;
    logic serial_out;
    modport device (input convert_start, input sclk, input serial_in,
        output serial_out);
    modport host (output convert_start, output sclk, input serial_out);
endinterface
`default_nettype wire

// ### hdl/adcdc_pkg.sv
// Shared constants for the daisy-chain converter readout link
package adcdc_pkg;
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CONV_CYCLES = 40;
    localparam int unsigned SCLK_HALF = 4;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [15:0] SAMPLE_RESET = 16'h0000;
    typedef enum logic [1:0] {ADCDC_IDLE, ADCDC_CONV, ADCDC_SHIFT} adcdc_dev_t;
    typedef enum logic [2:0]
    {
        ADCDC_H_IDLE, ADCDC_H_START, ADCDC_H_WAIT, ADCDC_H_LOW, ADCDC_H_HIGH,
        ADCDC_H_PUSH, ADCDC_H_END
    } adcdc_host_t;
endpackage

// ### verification/adc_daisy_chain_serial_readout_test.sv
// Testbench: two chained converters read back through the host end
`timescale 1ns/1ps
`default_nettype none
module adc_daisy_chain_serial_readout_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic use_busy = 1'b0;
    logic word_ready = 1'b0;
    logic [1:0] tie = 2'h0;
    logic [15:0] sample_a = 16'h0000;
    logic [15:0] sample_b = 16'h0000;
    logic running, word_valid, a_chain, a_busy, a_conv;
    logic [15:0] word_data;
    int n_fail = 0;
    int num_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    // ****************************************************************
    // Chain: tie selects ground, convert-start or high on device 1 input
    // ****************************************************************
    adcdc_if link_a();
    adcdc_if link_b();
    assign link_a.convert_start = link_b.convert_start;
    assign link_a.sclk = link_b.sclk;
    assign link_a.serial_in = (tie == 2'h0) ? 1'b0 :
        (tie == 2'h1) ? link_b.convert_start : 1'b1;
    assign link_b.serial_in = link_a.serial_out;

    adcdc_device u_adcdc_device (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(link_a), .sample(sample_a), .chain_mode(a_chain),
        .busy_mode(a_busy), .converting(a_conv));
    adcdc_device u_adcdc_device_b (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(link_b), .sample(sample_b), .chain_mode(),
        .busy_mode(), .converting());
    adcdc_host #(.N_DEV(2)) u_adcdc_host (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(link_b), .start(start), .use_busy(use_busy),
        .running(running), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data));
    adcdc_assertions #(.N_DEV(2)) u_adcdc_assertions (.sys_clk(sys_clk),
        .rst_n(rst_n), .convert_start(link_a.convert_start),
        .sclk(link_a.sclk), .serial_in(link_a.serial_in),
        .serial_out(link_a.serial_out));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic get_word(input logic [15:0] exp);
        int i;
        i = 0;
        @(negedge sys_clk);
        while (word_valid !== 1'b1 && i < 3000)
        begin
            @(negedge sys_clk);
            i++;
        end
        if (i == 3000)
        begin
            n_fail++;
            finish_test();
        end
        chk(word_data, exp);
        word_ready = 1'b1;
        @(negedge sys_clk);
        word_ready = 1'b0;
    endtask

    task automatic wait_idle;
        int i;
        i = 0;
        while (running !== 1'b0 && i < 3000)
        begin
            @(negedge sys_clk);
            i++;
        end
        if (i == 3000)
        begin
            n_fail++;
            finish_test();
        end
    endtask

    task automatic pulse_start(input logic b);
        @(negedge sys_clk);
        use_busy = b;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
    endtask

    // One frame; a second start while running must be refused
    task automatic frame(input logic b, input logic [1:0] t,
        input logic [15:0] sa, input logic [15:0] sb);
        logic chain;
        chain = (t != 2'h2);
        tie = t;
        sample_a = sa;
        sample_b = sb;
        pulse_start(b);
        repeat (20) @(negedge sys_clk);
        chk({15'h0000, a_conv}, {15'h0000, chain});
        chk({14'h0000, a_chain, a_busy}, {14'h0000, chain, b && chain});
        pulse_start(~b);
        get_word(sb);
        get_word(chain ? sa : 16'h0000);
        wait_idle();
        repeat (20) @(negedge sys_clk);
        chk({15'h0000, word_valid}, 16'h0000);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        frame(1'b0, 2'h0, 16'hA5C3, 16'h3C5A);
        frame(1'b1, 2'h1, 16'h8001, 16'hFFFF);
        frame(1'b0, 2'h0, 16'h0000, 16'h7FFE);
        frame(1'b1, 2'h1, 16'hFFFF, 16'h0000);
        frame(1'b0, 2'h2, 16'h1234, 16'h4321);
        for (int f = 0; f < 8; f++)
        begin
            tie = {1'b0, f[0]};
            sample_a = {8'h11, f[7:0]};
            sample_b = {8'h22, f[7:0]};
            pulse_start(f[0]);
            wait_idle();
        end
        tie = 2'h0;
        sample_a = 16'h9999;
        sample_b = 16'h6666;
        pulse_start(1'b0);
        repeat (600) @(negedge sys_clk);
        chk({15'h0000, running}, 16'h0001);
        for (int f = 0; f < 8; f++)
        begin
            get_word({8'h22, f[7:0]});
            get_word({8'h11, f[7:0]});
        end
        get_word(16'h6666);
        get_word(16'h9999);
        wait_idle();
        finish_test();
    end
endmodule
`default_nettype wire

// ### verification/adcdc_assertions.sv
// Concurrent checks on the pins of the first converter in the chain
`timescale 1ns/1ps
`default_nettype none
module adcdc_assertions #(
    parameter int unsigned N_DEV = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic convert_start,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic serial_out
);
    // ****************************************************************
    // Frame tracking
    // ****************************************************************
    logic cs_q, sclk_q, si_q, busy_q, busy_d, ign_q, ign_d;
    logic [7:0] rises_q, rises_d;

    always_comb
    begin
        rises_d = rises_q;
        busy_d = busy_q;
        ign_d = ign_q;
        if (convert_start && !cs_q)
        begin
            rises_d = 8'h00;
            busy_d = sclk;
            ign_d = si_q;
        end
        else if (convert_start && sclk && !sclk_q)
        begin
            rises_d = rises_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_q <= 1'b0;
            sclk_q <= 1'b0;
            si_q <= 1'b0;
            busy_q <= 1'b0;
            ign_q <= 1'b0;
            rises_q <= 8'h00;
        end
        else
        begin
            cs_q <= convert_start;
            sclk_q <= sclk;
            si_q <= serial_in;
            busy_q <= busy_d;
            ign_q <= ign_d;
            rises_q <= rises_d;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence conv_quiet;
        (!serial_out)[*8] ##1 (!serial_out)[*8] ##1 (!serial_out)[*8];
    endsequence

    AST_IDLE_LOW: assert property ((!convert_start)[*5] |-> !serial_out)
        else $error("output not low while idle");
    AST_CONV_LOW: assert property ($rose(convert_start) |=> conv_quiet)
        else $error("output moved during conversion");
    AST_HOLD_HIGH: assert property
        ((sclk && convert_start)[*3] |-> $stable(serial_out))
        else $error("output changed while serial clock high");
    AST_PULSES: assert property
        ((cs_q && !convert_start) |-> (rises_q == 16 * N_DEV + busy_q))
        else $error("wrong serial clock count in frame");
    AST_BUSY_BIT: assert property
        ((cs_q && convert_start && busy_q && rises_q == 8'h00) |-> !serial_out)
        else $error("busy bit not low ahead of data");
    AST_TAIL_LOW: assert property
        ((cs_q && convert_start && !busy_q && !ign_q && !serial_in
        && rises_q >= 8'h11) |-> !serial_out)
        else $error("first device not low after its word");
    AST_TAIL_HIGH: assert property
        ((cs_q && convert_start && busy_q && serial_in && rises_q >= 8'h12)
        |-> serial_out)
        else $error("first device not high after its word");
    AST_CS_IGNORED: assert property ((cs_q && ign_q) |-> !serial_out)
        else $error("output driven in non-chain start");
endmodule
`default_nettype wire
